// File: logic/pxcal_ctrl.v
// scanner-side controller: pixel gain bus, result capture and calibration sequencer
`timescale 1ns/1ps
`include "pxcal_regs.vh"
module pxcal_ctrl #(
  parameter IW = 12
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire [7:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [7:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  input  wire          conversion_done_n,
  output reg           output_enable_n,
  input  wire          line_sync,
  input  wire [7:0]    pixel_bus_in,
  output reg  [7:0]    pixel_gain_bus,
  output wire          pixel_gain_bus_oe,
  output reg  [IW-1:0] coef_addr,
  input  wire [7:0]    coef_data,
  output reg  [7:0]    pixel_data,
  output reg           pixel_strobe,
  output reg  [3:0]    coarse_gain,
  output reg           offset_dac_sign,
  output reg  [3:0]    offset_dac_mag,
  output reg           offset_add
);
  // sequencer states
  localparam S_IDLE  = 4'h0;
  localparam S_O1S   = 4'h1;
  localparam S_O1    = 4'h2;
  localparam S_O2S   = 4'h3;
  localparam S_O2    = 4'h4;
  localparam S_OCALC = 4'h5;
  localparam S_GS    = 4'h6;
  localparam S_G     = 4'h7;
  localparam S_GEVAL = 4'h8;

  reg [3:0]    state;
  reg [2:0]    result;
  reg          coef_en;
  reg [7:0]    target;
  reg [IW-1:0] first_px;
  reg [IW-1:0] last_px;
  reg [7:0]    black_low;
  reg [7:0]    black_high;
  reg [10:0]   residual;
  reg [7:0]    cal_code;
  reg          done_n_q;
  reg          sync_q;
  reg [7:0]    data_hold;
  reg [IW-1:0] px_idx;

  wire       stats_done;
  wire [7:0] stats_avg;
  wire [7:0] stats_min;
  wire [7:0] stats_max;

  wire cal_active = (state != S_IDLE);
  wire px_rise    = conversion_done_n & ~done_n_q;
  wire line_start = line_sync & ~sync_q;
  wire line_end   = ~line_sync & sync_q;
  // the index has already stepped when the capture pulse stands
  wire [IW-1:0] cap_idx = px_idx - 1'b1;
  wire px_in_win  = sync_q && (cap_idx >= first_px) && (cap_idx <= last_px);

  // shared bus: codes drive only while the device output is disabled
  assign pixel_gain_bus_oe = output_enable_n;

  // device enable follows its own strobe, one flop late, never overlapping our drive
  always @(posedge aclk) begin
    if (!aresetn) begin
      output_enable_n <= 1'b1;
      done_n_q        <= 1'b1;
      sync_q          <= 1'b0;
    end else begin
      output_enable_n <= conversion_done_n;
      done_n_q        <= conversion_done_n;
      sync_q          <= line_sync;
    end
  end

  // hold result while device drives, capture it on the strobe's rising edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      data_hold    <= 8'h00;
      pixel_data   <= 8'h00;
      pixel_strobe <= 1'b0;
    end else begin
      pixel_strobe <= 1'b0;
      if (!conversion_done_n && !output_enable_n) data_hold <= pixel_bus_in;
      if (px_rise && sync_q) begin
        pixel_data   <= data_hold;
        pixel_strobe <= 1'b1;
      end
    end
  end

  // pixel index restarts each line and walks the coefficient memory in order
  always @(posedge aclk) begin
    if (!aresetn) begin
      px_idx    <= {IW{1'b0}};
      coef_addr <= {IW{1'b0}};
    end else begin
      if (line_start) begin
        px_idx    <= {IW{1'b0}};
        coef_addr <= {IW{1'b0}};
      end else if (px_rise && sync_q) begin
        px_idx    <= px_idx + 1'b1;
        coef_addr <= px_idx + 1'b1;
      end
    end
  end

  // per-pixel code: calibration override or stored coefficient, zero when disabled
  always @(posedge aclk) begin
    if (!aresetn) begin
      pixel_gain_bus <= 8'h00;
    end else if (cal_active) begin
      pixel_gain_bus <= cal_code;
    end else begin
      pixel_gain_bus <= coef_en ? coef_data : 8'h00;
    end
  end

  pxcal_stats #(
    .DW (8),
    .IW (IW)
  ) u_stats (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clear    (line_start),
    .px_valid (pixel_strobe && px_in_win),
    .px_data  (pixel_data),
    .line_end (line_end),
    .avg      (stats_avg),
    .min_code (stats_min),
    .max_code (stats_max),
    .done     (stats_done)
  );

  // offset arithmetic from the two black averages
  wire signed [15:0] diff    = $signed({8'h00, black_low}) - $signed({8'h00, black_high});
  wire signed [15:0] prod    = diff * `PXCAL_DAC_MUL;
  wire signed [15:0] dac_raw = (prod >>> 5) + `PXCAL_DAC_BASE;
  wire signed [15:0] dac_neg = 16'sh0000 - dac_raw;
  wire [9:0]         tri_low = {2'b00, black_low} + {1'b0, black_low, 1'b0};
  wire               add_req = tri_low < {2'b00, black_high};
  wire signed [10:0] res_raw = $signed({1'b0, tri_low}) - $signed({3'b000, black_high});

  // coarse gain evaluation on the white line
  wire [12:0] max_x10 = {5'h00, stats_max} * `PXCAL_RATIO_DEN;
  wire [12:0] min_x28 = {5'h00, stats_min} * `PXCAL_RATIO_NUM;
  wire [12:0] tgt_x10 = {5'h00, target} * `PXCAL_RATIO_DEN;
  wire        clip    = (stats_max == `PXCAL_CLIP_CODE) || (stats_max > target);
  wire        vary    = max_x10 > min_x28;
  wire        inrange = min_x28 >= tgt_x10;

  // bus handshake and write decode
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire rd_go = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = !s_axi_rvalid;

  wire wr_ctrl   = wr_go && (s_axi_awaddr == `PXCAL_CTRL_OFS) && s_axi_wstrb[0];
  wire wr_target = wr_go && (s_axi_awaddr == `PXCAL_TARGET_OFS) && s_axi_wstrb[0];
  wire wr_window = wr_go && (s_axi_awaddr == `PXCAL_WINDOW_OFS);
  wire wr_config = wr_go && (s_axi_awaddr == `PXCAL_CONFIG_OFS) && !cal_active;
  wire wr_map    = (s_axi_awaddr == `PXCAL_CTRL_OFS) || (s_axi_awaddr == `PXCAL_STATUS_OFS) ||
                   (s_axi_awaddr == `PXCAL_TARGET_OFS) || (s_axi_awaddr == `PXCAL_WINDOW_OFS) ||
                   (s_axi_awaddr == `PXCAL_BLACK_OFS) || (s_axi_awaddr == `PXCAL_OFFSET_OFS) ||
                   (s_axi_awaddr == `PXCAL_CONFIG_OFS);

  // write response channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PXCAL_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_map ? `PXCAL_RESP_OKAY : `PXCAL_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // software-written settings
  always @(posedge aclk) begin
    if (!aresetn) begin
      coef_en  <= 1'b0;
      target   <= `PXCAL_TARGET_RST;
      first_px <= `PXCAL_FIRST_RST;
      last_px  <= `PXCAL_LAST_RST;
    end else begin
      if (wr_ctrl) coef_en <= s_axi_wdata[`PXCAL_CTRL_COEF_EN];
      if (wr_target) target <= s_axi_wdata[7:0];
      if (wr_window && s_axi_wstrb[1] && s_axi_wstrb[0]) first_px <= s_axi_wdata[IW-1:0];
      if (wr_window && s_axi_wstrb[3] && s_axi_wstrb[2]) last_px <= s_axi_wdata[16+IW-1:16];
    end
  end

  // calibration sequencer and device configuration outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      state           <= S_IDLE;
      result          <= `PXCAL_RES_NONE;
      cal_code        <= 8'h00;
      black_low       <= 8'h00;
      black_high      <= 8'h00;
      residual        <= 11'h000;
      coarse_gain     <= 4'h0;
      offset_dac_sign <= 1'b0;
      offset_dac_mag  <= 4'h0;
      offset_add      <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          if (wr_config && s_axi_wstrb[0]) begin
            coarse_gain    <= s_axi_wdata[`PXCAL_CFG_COARSE_LO+3:`PXCAL_CFG_COARSE_LO];
            offset_dac_mag <= s_axi_wdata[`PXCAL_CFG_MAG_LO+3:`PXCAL_CFG_MAG_LO];
          end
          if (wr_config && s_axi_wstrb[1]) begin
            offset_dac_sign <= s_axi_wdata[`PXCAL_CFG_SIGN];
            offset_add      <= s_axi_wdata[`PXCAL_CFG_ADD];
          end
          if (wr_ctrl && s_axi_wdata[`PXCAL_CTRL_START]) begin
            coarse_gain     <= 4'h0;
            offset_dac_sign <= 1'b0;
            offset_dac_mag  <= `PXCAL_DAC_MAX;
            offset_add      <= 1'b0;
            cal_code        <= 8'h00;
            result          <= `PXCAL_RES_NONE;
            state           <= S_O1S;
          end
        end
        S_O1S: if (line_start) state <= S_O1;
        S_O1: begin
          if (stats_done) begin
            black_low <= stats_avg;
            cal_code  <= `PXCAL_GAIN_HIGH;
            state     <= S_O2S;
          end
        end
        S_O2S: if (line_start) state <= S_O2;
        S_O2: begin
          if (stats_done) begin
            black_high <= stats_avg;
            state      <= S_OCALC;
          end
        end
        S_OCALC: begin
          if (dac_raw > `PXCAL_DAC_BASE) begin
            offset_dac_sign <= 1'b0;
            offset_dac_mag  <= `PXCAL_DAC_MAX;
          end else if (dac_raw < -`PXCAL_DAC_BASE) begin
            offset_dac_sign <= 1'b1;
            offset_dac_mag  <= `PXCAL_DAC_MAX;
          end else if (dac_raw < 16'sh0000) begin
            offset_dac_sign <= 1'b1;
            offset_dac_mag  <= dac_neg[3:0];
          end else begin
            offset_dac_sign <= 1'b0;
            offset_dac_mag  <= dac_raw[3:0];
          end
          offset_add <= add_req;
          residual   <= (res_raw >>> 1) + (add_req ? 11'sh002 : 11'sh000);
          cal_code   <= 8'h00;
          coarse_gain <= 4'h0;
          state      <= S_GS;
        end
        S_GS: if (line_start) state <= S_G;
        S_G: if (stats_done) state <= S_GEVAL;
        S_GEVAL: begin
          if (clip) begin
            result <= `PXCAL_RES_STRONG;
            state  <= S_IDLE;
          end else if (vary) begin
            result <= `PXCAL_RES_VARY;
            state  <= S_IDLE;
          end else if (inrange) begin
            result <= `PXCAL_RES_OK;
            state  <= S_IDLE;
          end else if (coarse_gain == `PXCAL_COARSE_MAX) begin
            result <= `PXCAL_RES_WEAK;
            state  <= S_IDLE;
          end else if (!line_sync) begin
            coarse_gain <= coarse_gain + 4'h1;
            state       <= S_GS;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // register read mux
  reg [31:0] rd_word;
  reg        rd_hit;
  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `PXCAL_CTRL_OFS:   rd_word = {30'h0, coef_en, 1'b0};
      `PXCAL_STATUS_OFS: rd_word = {24'h0, state, 1'b0, result};
      `PXCAL_TARGET_OFS: rd_word = {24'h0, target};
      `PXCAL_WINDOW_OFS: rd_word = {{(16-IW){1'b0}}, last_px, {(16-IW){1'b0}}, first_px};
      `PXCAL_BLACK_OFS:  rd_word = {16'h0, black_high, black_low};
      `PXCAL_OFFSET_OFS: rd_word = {{5{residual[10]}}, residual, 16'h0000};
      `PXCAL_CONFIG_OFS: rd_word = {22'h0, offset_add, offset_dac_sign, offset_dac_mag,
                                    coarse_gain};
      default: rd_hit = 1'b0;
    endcase
  end

  // read data channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `PXCAL_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? `PXCAL_RESP_OKAY : `PXCAL_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// File: inc/pxcal_regs.vh
// register map, field layout and constants of the pixel port and calibration controller
//
// Overview of operation
// - drive 8-bit gain code every pixel
// - capture pixel result on strobe rising edge
// - enable follows strobe; codes driven while high
// - offset start: gain 0, dac max, add 0
// - average black lines at code 0, 255
// - dac = 15 + 39*(low-high)/32
// - add bit set when 3*low below high
// - residual = (3*low-high)/2, plus two if add
// - coarse search from unity, step until outcome
// - success when whites within target and target/2.8
// - too strong when any white pixel clips
// - target code default near full scale, 250
// - resend stored coefficients every scanned line
// - coefficient = 256/1.95*(target/uncorrected-1), software computes
// - change coarse gain only between lines
`ifndef PXCAL_REGS_VH
`define PXCAL_REGS_VH

// register byte offsets
`define PXCAL_CTRL_OFS     8'h00
`define PXCAL_STATUS_OFS   8'h04
`define PXCAL_TARGET_OFS   8'h08
`define PXCAL_WINDOW_OFS   8'h0C
`define PXCAL_BLACK_OFS    8'h10
`define PXCAL_OFFSET_OFS   8'h14
`define PXCAL_CONFIG_OFS   8'h18

// control fields
`define PXCAL_CTRL_START   0
`define PXCAL_CTRL_COEF_EN 1

// config fields
`define PXCAL_CFG_COARSE_LO 0
`define PXCAL_CFG_MAG_LO    4
`define PXCAL_CFG_SIGN      8
`define PXCAL_CFG_ADD       9

// reset values
`define PXCAL_TARGET_RST   8'hFA
`define PXCAL_FIRST_RST    12'h000
`define PXCAL_LAST_RST     12'hFFF

// calibration outcome codes
`define PXCAL_RES_NONE     3'h0
`define PXCAL_RES_OK       3'h1
`define PXCAL_RES_STRONG   3'h2
`define PXCAL_RES_VARY     3'h3
`define PXCAL_RES_WEAK     3'h4
`define PXCAL_RES_OFS_DONE 3'h5

// calibration constants
`define PXCAL_DAC_MAX      4'hF
`define PXCAL_DAC_BASE     16'sh000F
`define PXCAL_DAC_MUL      16'sh0027
`define PXCAL_GAIN_HIGH    8'hFF
`define PXCAL_CLIP_CODE    8'hFF
`define PXCAL_RATIO_NUM    13'h001C
`define PXCAL_RATIO_DEN    13'h000A
`define PXCAL_COARSE_MAX   4'hF

// axi responses
`define PXCAL_RESP_OKAY    2'h0
`define PXCAL_RESP_SLVERR  2'h2

`endif

// File: logic/pxcal_stats.v
// per-line pixel statistics: sum, count, minimum, maximum and average by division
`timescale 1ns/1ps
module pxcal_stats #(
  parameter DW = 8,
  parameter IW = 12
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          clear,
  input  wire          px_valid,
  input  wire [DW-1:0] px_data,
  input  wire          line_end,
  output reg  [DW-1:0] avg,
  output reg  [DW-1:0] min_code,
  output reg  [DW-1:0] max_code,
  output reg           done
);
  localparam SW = DW + IW;
  localparam [IW-1:0] STEPS = DW + IW; // one division step per sum bit

  reg [SW-1:0] sum;
  reg [IW-1:0] cnt;
  reg [SW-1:0] rem;
  reg [SW-1:0] quo;
  reg [IW-1:0] step;
  reg          busy;

  wire [SW:0] rem_w   = {rem, quo[SW-1]};
  wire [SW:0] cnt_ext = {{(SW+1-IW){1'b0}}, cnt};

  // accumulate valid pixels, then restoring division of sum by count
  always @(posedge aclk) begin
    if (!aresetn) begin
      sum      <= {SW{1'b0}};
      cnt      <= {IW{1'b0}};
      rem      <= {SW{1'b0}};
      quo      <= {SW{1'b0}};
      step     <= {IW{1'b0}};
      busy     <= 1'b0;
      done     <= 1'b0;
      avg      <= {DW{1'b0}};
      min_code <= {DW{1'b1}};
      max_code <= {DW{1'b0}};
    end else begin
      done <= 1'b0;
      if (clear) begin
        sum      <= {SW{1'b0}};
        cnt      <= {IW{1'b0}};
        busy     <= 1'b0;
        min_code <= {DW{1'b1}};
        max_code <= {DW{1'b0}};
      end else if (busy) begin
        if (rem_w >= cnt_ext) begin
          rem <= rem_w[SW-1:0] - cnt_ext[SW-1:0];
          quo <= {quo[SW-2:0], 1'b1};
        end else begin
          rem <= rem_w[SW-1:0];
          quo <= {quo[SW-2:0], 1'b0};
        end
        step <= step - 1'b1;
        if (step == {{(IW-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
          avg  <= rem_w >= cnt_ext ? {quo[DW-2:0], 1'b1} : {quo[DW-2:0], 1'b0};
        end
      end else if (line_end) begin
        if (cnt == {IW{1'b0}}) begin
          avg  <= {DW{1'b0}}; // empty window reads as zero
          done <= 1'b1;
        end else begin
          rem  <= {SW{1'b0}};
          quo  <= sum;
          step <= STEPS;
          busy <= 1'b1;
        end
      end else if (px_valid) begin
        sum <= sum + {{IW{1'b0}}, px_data};
        cnt <= cnt + 1'b1;
        if (px_data < min_code) min_code <= px_data;
        if (px_data > max_code) max_code <= px_data;
      end
    end
  end
endmodule

// File: test/pxcal_chk.sv
// concurrent checks on the pixel port and register bus of the controller
`timescale 1ns/1ps
module pxcal_chk #(
  parameter IW = 12
) (
  input wire          aclk,
  input wire          aresetn,
  input wire          s_axi_awvalid,
  input wire          s_axi_wvalid,
  input wire          s_axi_bvalid,
  input wire          s_axi_arvalid,
  input wire          s_axi_arready,
  input wire          s_axi_rvalid,
  input wire          conversion_done_n,
  input wire          output_enable_n,
  input wire          line_sync,
  input wire          pixel_gain_bus_oe,
  input wire [IW-1:0] coef_addr,
  input wire          pixel_strobe,
  input wire [3:0]    coarse_gain
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // shared bus ownership follows the strobe
  oe_follow_a: assert property (output_enable_n == $past(conversion_done_n))
    else $error("enable not one clock behind strobe");
  bus_share_a: assert property (pixel_gain_bus_oe == output_enable_n)
    else $error("code driven while device enabled");
  // capture on the rising strobe inside a line
  pixel_capture_a: assert property (
    $rose(conversion_done_n) && $past(line_sync) |=> pixel_strobe)
    else $error("capture missed");
  strobe_cause_a: assert property (pixel_strobe |->
    $past(conversion_done_n) && !$past(conversion_done_n, 2) && $past(line_sync, 2))
    else $error("capture without strobe rise");
  strobe_pulse_a: assert property (pixel_strobe |=> !pixel_strobe)
    else $error("capture pulse too long");
  // coefficient fetch runs in pixel order; coarse gain holds within a line
  addr_step_a: assert property (pixel_strobe |->
    coef_addr == $past(coef_addr) + 1'b1)
    else $error("coefficient address did not step");
  line_zero_a: assert property ($rose(line_sync) |-> ##[1:2] coef_addr == '0)
    else $error("address not restarted at line");
  coarse_hold_a: assert property ($changed(coarse_gain) |-> !$past(line_sync))
    else $error("coarse gain changed within a line");
  // register bus answers one clock after acceptance
  write_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule
bind pxcal_ctrl pxcal_chk #(.IW(IW)) pxcal_chk_inst (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_wvalid, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .conversion_done_n, .output_enable_n, .line_sync, .pixel_gain_bus_oe, .coef_addr,
  .pixel_strobe, .coarse_gain);

// File: test/pxcal_dev_model.sv
// behavioural model of the converter device on the pixel port
`timescale 1ns/1ps
module pxcal_dev_model (
  input wire        aclk,
  input wire        go,
  input wire [7:0]  npix,
  input wire [7:0]  base,
  input wire [7:0]  span,
  input wire [3:0]  coarse_gain,
  input wire        offset_dac_sign,
  input wire [3:0]  offset_dac_mag,
  input wire        offset_add,
  input wire        output_enable_n,
  input wire [7:0]  pixel_gain_bus,
  input wire        pixel_gain_bus_oe,
  output reg        conversion_done_n = 1'b1,
  output reg        line_sync = 1'b0,
  output wire [7:0] pixel_bus_in,
  output reg [7:0]  dev_code = 8'h00,
  output reg [7:0]  gain_used = 8'h00,
  output reg        px_done = 1'b0,
  output reg        busy = 1'b0
);
  reg [7:0] last = 8'h00;
  integer   i;
  integer   m;
  integer   v;
  // bus level: code, result, or a float that toggles every clock
  assign pixel_bus_in = pixel_gain_bus_oe ? pixel_gain_bus :
                        !output_enable_n ? dev_code : ~last;
  always @(posedge aclk) last <= pixel_bus_in;
  // one line of pixels for each go pulse
  always begin
    @(posedge aclk);
    if (go) begin
      busy <= 1'b1;
      line_sync <= 1'b1;
      repeat (4) @(posedge aclk);
      for (i = 0; i < npix; i = i + 1) begin
        m = offset_dac_mag * 27 / 64;
        v = (base + (i * 37) % (span + 1)) * (16 + 2 * coarse_gain) / 16;
        v = offset_dac_sign ? v - m : v + m;
        if (v < 0) v = 0;
        v = v + v * pixel_gain_bus / 131 + (offset_add ? 2 : 0);
        dev_code <= v > 255 ? 8'hFF : v[7:0];
        gain_used <= pixel_gain_bus;
        conversion_done_n <= 1'b0;
        repeat (3) @(posedge aclk);
        conversion_done_n <= 1'b1;
        px_done <= 1'b1;
        @(posedge aclk);
        px_done <= 1'b0;
        repeat (3) @(posedge aclk);
      end
      line_sync <= 1'b0;
      busy <= 1'b0;
    end
  end
endmodule

// File: test/pxcal_ctrl_tb_top.sv
// self-checking bench for the pixel port and calibration controller
`timescale 1ns/1ps
`include "pxcal_regs.vh"
module pxcal_ctrl_tb_top;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg  [7:0]  s_axi_awaddr = 8'h00;
  reg  [7:0]  s_axi_araddr = 8'h00;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'hF;
  reg         s_axi_awvalid = 1'b0;
  reg         s_axi_wvalid = 1'b0;
  reg         s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0;
  reg         s_axi_rready = 1'b0;
  reg  [7:0]  coef_data = 8'h00;
  reg         go = 1'b0;
  reg  [7:0]  npix = 8'h10;
  reg  [7:0]  base = 8'h00;
  reg  [7:0]  span = 8'h00;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        conversion_done_n, output_enable_n, line_sync, pixel_gain_bus_oe;
  wire        pixel_strobe, offset_dac_sign, offset_add, px_done, busy;
  wire [7:0]  pixel_bus_in, pixel_gain_bus, pixel_data, dev_code, gain_used;
  wire [11:0] coef_addr;
  wire [3:0]  coarse_gain, offset_dac_mag;
  reg  [7:0]  mem [0:4095];
  reg  [7:0]  q [$];
  reg  [31:0] rd_data;
  reg  [1:0]  resp;
  integer     errors = 0, checks_done = 0, seed = 66728;
  integer     mode = 0, idx, sum, cnt, mn, mx, lo, hi, d, res, k, r, i;
  always #5 aclk = ~aclk;
  pxcal_ctrl #(.IW(12)) pxcal_ctrl_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conversion_done_n,
    .output_enable_n, .line_sync, .pixel_bus_in, .pixel_gain_bus, .pixel_gain_bus_oe,
    .coef_addr, .coef_data, .pixel_data, .pixel_strobe, .coarse_gain, .offset_dac_sign,
    .offset_dac_mag, .offset_add);
  pxcal_dev_model pxcal_dev_model_inst (.aclk, .go, .npix, .base, .span, .coarse_gain,
    .offset_dac_sign, .offset_dac_mag, .offset_add, .output_enable_n, .pixel_gain_bus,
    .pixel_gain_bus_oe, .conversion_done_n, .line_sync, .pixel_bus_in, .dev_code,
    .gain_used, .px_done, .busy);
  // coefficient memory with one clock of read latency
  always @(posedge aclk) coef_data <= mem[coef_addr];
  task chk(input [31:0] got, input [31:0] exp, input string what);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // one scanned line, then a gap with line sync low
  task line(input integer m, input [7:0] b, input [7:0] sp);
    @(posedge aclk);
    mode = m;
    idx = 0;
    sum = 0;
    cnt = 0;
    mn = 255;
    mx = 0;
    base <= b;
    span <= sp;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    do @(posedge aclk); while (busy);
    repeat (40) @(posedge aclk);
  endtask
  task calib(input [7:0] wb, input [7:0] ws);
    wr(`PXCAL_CTRL_OFS, 32'h1);
    line(2, 8'h02 + {$random(seed)} % 4, 8'h03);
    lo = sum / cnt;
    line(3, 8'h02 + {$random(seed)} % 4, 8'h03);
    hi = sum / cnt;
    rd(`PXCAL_BLACK_OFS);
    chk(rd_data[15:0], {hi[7:0], lo[7:0]}, "black averages");
    d = 15 + ((39 * (lo - hi)) >>> 5);
    d = d > 15 ? 15 : (d < -15 ? -15 : d);
    k = d < 0 ? -d : d;
    chk({offset_dac_sign, offset_dac_mag}, {d < 0, k[3:0]}, "offset dac");
    r = 3 * lo < hi;
    chk(offset_add, r, "offset add");
    res = ((3 * lo - hi) >>> 1) + 2 * r;
    rd(`PXCAL_OFFSET_OFS);
    chk(rd_data[31:16], res[15:0], "residual");
    k = 0;
    r = 0;
    while (r == 0) begin
      line(0, wb, ws);
      r = (mx == 255 || mx > 250) ? 2 : (10 * mx > 28 * mn) ? 3 :
          (28 * mn >= 2500) ? 1 : (k == 15) ? 4 : 0;
      if (r == 0) k = k + 1;
    end
    do rd(`PXCAL_STATUS_OFS); while (rd_data[7:4] !== 4'h0);
    chk(rd_data[2:0], r, "outcome");
    chk(coarse_gain, k, "coarse gain");
    $display("test calibration done");
  endtask
  // log device results, check captures and the codes the device saw
  always @(posedge aclk) begin
    if (px_done) begin
      q.push_back(dev_code);
      if (idx >= 2 && idx <= 13) begin
        sum = sum + dev_code;
        cnt = cnt + 1;
        if (dev_code < mn) mn = dev_code;
        if (dev_code > mx) mx = dev_code;
      end
      if (mode == 1) chk(gain_used, mem[idx], "gain code");
      if (mode == 2) chk({coarse_gain, offset_dac_sign, offset_dac_mag, offset_add, gain_used},
                         {4'h0, 1'b0, 4'hF, 1'b0, 8'h00}, "offset start");
      if (mode == 3) chk(gain_used, 8'hFF, "high gain code");
      idx = idx + 1;
    end
    if (pixel_strobe) chk(pixel_data, q.pop_front(), "pixel data");
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #500000;
    errors = errors + 1;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict;
  end
  initial begin
    for (i = 0; i < 4096; i = i + 1)
      mem[i] = $random(seed);
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PXCAL_TARGET_OFS);
    chk(rd_data, 32'hFA, "target reset");
    rd(`PXCAL_WINDOW_OFS);
    chk(rd_data, 32'h0FFF0000, "window reset");
    rd(8'h1C);
    chk({resp, rd_data[29:0]}, {`PXCAL_RESP_SLVERR, 30'h0}, "unmapped read");
    wr(8'h1C, 32'h0);
    chk(resp, `PXCAL_RESP_SLVERR, "unmapped write");
    $display("test registers done");
    i = {$random(seed)} % 1024;
    wr(`PXCAL_CONFIG_OFS, i);
    chk({offset_add, offset_dac_sign, offset_dac_mag, coarse_gain}, i, "config");
    wr(`PXCAL_WINDOW_OFS, 32'h000D0002);
    wr(`PXCAL_CTRL_OFS, 32'h2);
    line(1, {$random(seed)} % 128, {$random(seed)} % 64);
    line(1, {$random(seed)} % 128, {$random(seed)} % 64);
    $display("test coefficient lines done");
    calib(8'h1E + {$random(seed)} % 90, {$random(seed)} % 60);
    calib(8'hC8, 8'h37);
    calib(8'h19, 8'h00);
    print_verdict;
  end
endmodule
